// ---- logic/pss_scheduler.sv ----
// Periodic poll scheduler for one port, with AHB-Lite register slave
`timescale 1ns/1ps
module pss_scheduler
    import pss_pkg::*;
#(
    parameter int TICK_CYC = PSS_TICK_CYC
) (
    input  wire logic        hclk,           // Bus and block clock
    input  wire logic        hresetn,        // Async reset, active low
    input  wire logic        hsel,           // Slave select
    input  wire logic [15:0] haddr,          // Byte address
    input  wire logic [1:0]  htrans,         // Transfer type
    input  wire logic        hwrite,         // Write when high
    input  wire logic [2:0]  hsize,          // Transfer size
    input  wire logic        hready,         // Bus ready
    input  wire logic [31:0] hwdata,         // Write data
    output logic      [31:0] hrdata,         // Read data
    output logic             hreadyout,      // Slave ready
    output logic             hresp,          // Always OKAY
    input  wire logic [2:0]  port_num,       // Index of this port
    output logic             msg_valid,      // Message request
    input  wire logic        msg_ready,      // Message accepted
    output logic             msg_write,      // 1 = write, 0 = read
    output logic      [11:0] msg_local,      // First mailbox register
    output logic      [15:0] msg_remote,     // First remote register
    output logic      [7:0]  msg_count,      // Register count
    output logic      [15:0] msg_route,      // Drop path
    output logic      [5:0]  msg_entry,      // Entry number, zero based
    input  wire logic        rsp_valid,      // Reply pulse
    input  wire logic        rsp_ok,         // Reply without error
    output logic             xfer_inhibit,   // Single transfer disabled
    output logic             slave_allow     // Slave operation allowed
);

    logic [31:0] tbl_q [0:PSS_N_WORD-1];
    logic [15:0] wd_timer_q;
    logic [15:0] wd_mask_q;
    logic [15:0] interval_q;
    logic [15:0] ctrl_q;
    logic [47:0] status_q;
    logic [47:0] ent_ok;
    pss_state_t  state_q;
    logic [5:0]  ptr_q;
    logic [17:0] tick_cnt_q;
    logic        tick;
    logic [17:0] ivl_sub_q;
    logic        ivl_tick;
    logic [15:0] ivl_cnt_q;
    logic        ivl_done;
    logic        pend_q;
    logic [5:0]  pend_ent_q;
    logic        late_q;
    logic [7:0]  extra_q;
    logic        wd_stop;
    logic        scan_en;
    logic        any_valid;
    logic        ap_wr_q;
    logic        ap_rd_q;
    logic [13:0] ap_idx_q;
    logic        ap_take;
    logic [13:0] ap_idx;
    logic        wd_wr;
    logic        take_msg;

    // Zero wait states keep the slave trivially correct for single transfers
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_take   = hsel && htrans[1] && hready;
    assign ap_idx    = haddr[15:2];
    assign wd_wr     = ap_wr_q && (ap_idx_q == PSS_IDX_WD_TIMER);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q  <= 1'b0;
            ap_rd_q  <= 1'b0;
            ap_idx_q <= 14'h0000;
        end else begin
            ap_wr_q  <= ap_take && hwrite;
            ap_rd_q  <= ap_take && !hwrite;
            ap_idx_q <= ap_idx;
        end
    end

    // Read data registered at the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            if (ap_idx >= PSS_IDX_TBL && ap_idx <= PSS_IDX_TBL_END) begin
                hrdata <= tbl_q[7'(ap_idx - PSS_IDX_TBL)];
            end else begin
                unique case (ap_idx)
                    PSS_IDX_WD_TIMER: hrdata <= {16'h0000, wd_timer_q};
                    PSS_IDX_WD_MASK:  hrdata <= {16'h0000, wd_mask_q};
                    PSS_IDX_INTERVAL: hrdata <= {16'h0000, interval_q};
                    PSS_IDX_CTRL:     hrdata <= {16'h0000, ctrl_q};
                    PSS_IDX_STAT0:    hrdata <= {16'h0000, status_q[15:0]};
                    PSS_IDX_STAT1:    hrdata <= {16'h0000, status_q[31:16]};
                    PSS_IDX_STAT2:    hrdata <= {16'h0000, status_q[47:32]};
                    PSS_IDX_SCHED:    hrdata <= {16'h0000, pend_q, late_q, ptr_q,
                                                 xfer_inhibit, slave_allow, wd_stop,
                                                 scan_en, 2'(state_q), 2'b00};
                    default:          hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_mask_q  <= PSS_WD_MASK_RST;
            interval_q <= PSS_INTERVAL_RST;
            ctrl_q     <= 16'h0000;
        end else if (ap_wr_q) begin
            if (ap_idx_q == PSS_IDX_WD_MASK) begin
                wd_mask_q <= hwdata[15:0];
            end
            if (ap_idx_q == PSS_IDX_INTERVAL) begin
                interval_q <= hwdata[15:0];
            end
            if (ap_idx_q == PSS_IDX_CTRL) begin
                ctrl_q <= hwdata[15:0];
            end
        end
    end

    // Table kept in flops so every entry's validity is known at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < PSS_N_WORD; i++) begin
                tbl_q[i] <= 32'h0000_0000;
            end
        end else if (ap_wr_q && ap_idx_q >= PSS_IDX_TBL && ap_idx_q <= PSS_IDX_TBL_END) begin
            tbl_q[7'(ap_idx_q - PSS_IDX_TBL)] <= hwdata;
        end
    end

    for (genvar e = 0; e < PSS_N_ENTRY; e++) begin : g_ent
        logic [11:0] loc;
        logic [15:0] rem;
        logic [7:0]  cnt;
        logic [15:0] rte;
        assign loc = tbl_q[2*e][PSS_F_LOCAL +: 12];
        assign rem = tbl_q[2*e][PSS_F_REMOTE +: 16];
        assign cnt = tbl_q[2*e+1][PSS_F_COUNT +: 8];
        assign rte = tbl_q[2*e+1][PSS_F_ROUTE +: 16];
        assign ent_ok[e] = ((loc != 12'h000 && loc <= PSS_LOCAL_LO_MAX)
                            || (loc >= PSS_LOCAL_HI_MIN && loc <= PSS_LOCAL_HI_MAX))
                           && rem != 16'h0000
                           && cnt != 8'h00 && cnt <= PSS_COUNT_MAX
                           && rte != 16'h0000;
    end

    assign any_valid    = |ent_ok;
    assign xfer_inhibit = any_valid;
    assign wd_stop      = (wd_timer_q == 16'h0000) && wd_mask_q[port_num];
    assign scan_en      = (interval_q != 16'h0000) && !wd_stop;
    // Scan table borrows the slave routing table, so slave mode must yield
    assign slave_allow  = !(ctrl_q[PSS_F_MODBUS] && any_valid && scan_en);

    assign tick = (tick_cnt_q == 18'(TICK_CYC - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 18'h00000;
        end else begin
            tick_cnt_q <= tick ? 18'h00000 : tick_cnt_q + 18'h00001;
        end
    end

    // Bus write wins over a decrement in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_timer_q <= PSS_WD_TIMER_RST;
        end else if (wd_wr) begin
            wd_timer_q <= hwdata[15:0];
        end else if (tick && wd_timer_q != 16'h0000) begin
            wd_timer_q <= wd_timer_q - 16'h0001;
        end
    end

    assign ivl_done = (ivl_cnt_q >= interval_q);
    assign take_msg = (state_q == PSS_ISSUE) && msg_ready;
    // Own timebase restarted at each take, so spacing is never a tick short
    assign ivl_tick = (ivl_sub_q == 18'(TICK_CYC - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ivl_sub_q <= 18'h00000;
        end else if (take_msg || ivl_tick) begin
            ivl_sub_q <= 18'h00000;
        end else begin
            ivl_sub_q <= ivl_sub_q + 18'h00001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ivl_cnt_q <= 16'h0000;
        end else if (take_msg) begin
            ivl_cnt_q <= 16'h0000;
        end else if (ivl_tick && ivl_cnt_q != 16'hFFFF) begin
            ivl_cnt_q <= ivl_cnt_q + 16'h0001;
        end
    end

    // Missing reply at expiry: hold off two seconds, then give up on it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            late_q  <= 1'b0;
            extra_q <= 8'h00;
        end else if (!late_q && pend_q && ivl_done && !rsp_valid) begin
            late_q  <= 1'b1;
            extra_q <= PSS_LATE_TICKS;
        end else if (late_q && ivl_tick) begin
            extra_q <= extra_q - 8'h01;
            if (extra_q == 8'h01) begin
                late_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q     <= 1'b0;
            pend_ent_q <= 6'h00;
        end else if (take_msg) begin
            pend_q     <= 1'b1;
            pend_ent_q <= ptr_q;
        end else if (rsp_valid || (late_q && ivl_tick && extra_q == 8'h01)) begin
            pend_q     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= PSS_IDLE;
            ptr_q   <= 6'h00;
        end else begin
            unique case (state_q)
                PSS_IDLE: begin
                    if (scan_en) begin
                        state_q <= PSS_SEEK;
                    end
                end
                PSS_SEEK: begin
                    if (!scan_en) begin
                        state_q <= PSS_IDLE;
                    end else if (!ent_ok[ptr_q]) begin
                        ptr_q <= (ptr_q == 6'd47) ? 6'h00 : ptr_q + 6'h01;
                    end else if (ivl_done && !pend_q && !late_q) begin
                        state_q <= PSS_ISSUE;
                    end
                end
                PSS_ISSUE: begin
                    // A raised request is never withdrawn before it is taken
                    if (msg_ready) begin
                        state_q <= PSS_SEEK;
                        ptr_q   <= (ptr_q == 6'd47) ? 6'h00 : ptr_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= PSS_IDLE;
                end
            endcase
        end
    end

    assign msg_valid = (state_q == PSS_ISSUE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msg_write  <= 1'b0;
            msg_local  <= 12'h000;
            msg_remote <= 16'h0000;
            msg_count  <= 8'h00;
            msg_route  <= 16'h0000;
            msg_entry  <= 6'h00;
        end else if (state_q == PSS_SEEK) begin
            msg_write  <= tbl_q[{ptr_q, 1'b0}][PSS_F_DIR];
            msg_local  <= tbl_q[{ptr_q, 1'b0}][PSS_F_LOCAL +: 12];
            msg_remote <= tbl_q[{ptr_q, 1'b0}][PSS_F_REMOTE +: 16];
            msg_count  <= tbl_q[{ptr_q, 1'b1}][PSS_F_COUNT +: 8];
            msg_route  <= tbl_q[{ptr_q, 1'b1}][PSS_F_ROUTE +: 16];
            msg_entry  <= ptr_q;
        end
    end

    // Reply result written last so it wins over a same-cycle skip clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= 48'h0000_0000_0000;
        end else if (!scan_en) begin
            status_q <= 48'h0000_0000_0000;
        end else begin
            if (state_q == PSS_SEEK && !ent_ok[ptr_q]) begin
                status_q[ptr_q] <= 1'b0;
            end
            if (late_q && ivl_tick && extra_q == 8'h01 && pend_q && !rsp_valid) begin
                status_q[pend_ent_q] <= 1'b0;
            end
            if (rsp_valid && pend_q) begin
                status_q[pend_ent_q] <= rsp_ok;
            end
        end
    end

    a_wd_halt: assert property (@(posedge hclk) disable iff (!hresetn)
        (wd_stop && !msg_valid) |=> !msg_valid)
        else $error("message raised while watchdog expired");
    a_wd_status_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        wd_stop |=> (status_q == 48'h0000_0000_0000))
        else $error("status not cleared by watchdog");
    a_ivl_zero_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (interval_q == 16'h0000 && !msg_valid) |=> !msg_valid)
        else $error("message raised with zero interval");
    a_issue_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(msg_valid) |-> $past(ivl_done) && !pend_q)
        else $error("message raised before interval elapsed");
    a_late_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (late_q && !msg_valid) |=> !msg_valid)
        else $error("message raised during late delay");
    a_local_range: assert property (@(posedge hclk) disable iff (!hresetn)
        msg_valid |-> ((msg_local != 12'h000 && msg_local <= 12'h020)
            || (msg_local >= 12'h041 && msg_local <= 12'h800)))
        else $error("message local pointer out of range");
    a_count_remote: assert property (@(posedge hclk) disable iff (!hresetn)
        msg_valid |-> (msg_count != 8'h00 && msg_count <= 8'h80
            && msg_remote != 16'h0000 && msg_route != 16'h0000))
        else $error("message count, remote or route invalid");
    a_wd_decrement: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && wd_timer_q != 16'h0000 && !wd_wr)
            |=> wd_timer_q == $past(wd_timer_q) - 16'h0001)
        else $error("watchdog did not count down");
    a_status_reply: assert property (@(posedge hclk) disable iff (!hresetn)
        (rsp_valid && pend_q && scan_en)
            |=> status_q[$past(pend_ent_q)] == $past(rsp_ok))
        else $error("status bit does not follow reply");
    a_slave_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q[0] && msg_valid) |-> !slave_allow)
        else $error("slave allowed while scanning");
endmodule

// ---- logic/pss_pkg.sv ----
// Constants, register map and state encoding of the periodic poll scheduler
package pss_pkg;
    // Register indices; byte address is four times the index
    localparam logic [13:0] PSS_IDX_WD_TIMER = 14'h1FFD;
    localparam logic [13:0] PSS_IDX_WD_MASK  = 14'h1FFE;
    localparam logic [13:0] PSS_IDX_INTERVAL = 14'h0080;
    localparam logic [13:0] PSS_IDX_CTRL     = 14'h0081;
    localparam logic [13:0] PSS_IDX_STAT0    = 14'h0090;
    localparam logic [13:0] PSS_IDX_STAT1    = 14'h0091;
    localparam logic [13:0] PSS_IDX_STAT2    = 14'h0092;
    localparam logic [13:0] PSS_IDX_SCHED    = 14'h0093;
    localparam logic [13:0] PSS_IDX_TBL      = 14'h0100;
    localparam logic [13:0] PSS_IDX_TBL_END  = 14'h015F;

    localparam int          PSS_N_ENTRY   = 48;
    localparam int          PSS_N_WORD    = 96;
    localparam int          PSS_N_PORT    = 5;
    // Entry word 0: remote [15:0], local [27:16], direction [31] (1 = write)
    localparam int          PSS_F_REMOTE  = 0;
    localparam int          PSS_F_LOCAL   = 16;
    localparam int          PSS_F_DIR     = 31;
    // Entry word 1: count [7:0], route [23:8]
    localparam int          PSS_F_COUNT   = 0;
    localparam int          PSS_F_ROUTE   = 8;
    // Ctrl word: bit 0 = port runs in Modbus mode
    localparam int          PSS_F_MODBUS  = 0;

    localparam logic [11:0] PSS_LOCAL_LO_MAX = 12'h020;
    localparam logic [11:0] PSS_LOCAL_HI_MIN = 12'h041;
    localparam logic [11:0] PSS_LOCAL_HI_MAX = 12'h800;
    localparam logic [7:0]  PSS_COUNT_MAX    = 8'h80;

    localparam logic [15:0] PSS_WD_TIMER_RST = 16'h0000;
    localparam logic [15:0] PSS_WD_MASK_RST  = 16'h0000;
    localparam logic [15:0] PSS_INTERVAL_RST = 16'h0000;

    localparam int          PSS_CLK_KHZ    = 25000;
    localparam int          PSS_TICK_MS    = 10;
    localparam int          PSS_TICK_CYC   = PSS_TICK_MS * PSS_CLK_KHZ;
    localparam int          PSS_LATE_MS    = 2000;
    localparam logic [7:0]  PSS_LATE_TICKS = 8'(PSS_LATE_MS / PSS_TICK_MS);

    typedef enum logic [1:0] {
        PSS_IDLE  = 2'b00,
        PSS_SEEK  = 2'b01,
        PSS_ISSUE = 2'b11
    } pss_state_t;
endpackage

// ---- dv/pss_slave_model.sv ----
// Behavioural far-side target that accepts scan messages and replies
`timescale 1ns/1ps
module pss_slave_model (
    input  wire logic        hclk,      // Clock
    input  wire logic        hresetn,   // Reset, active low
    input  wire logic        msg_valid, // Request
    input  wire logic [5:0]  msg_entry, // Entry number
    input  wire logic [3:0]  rdy_lat,   // Accept delay
    input  wire logic [7:0]  rsp_lat,   // Reply delay
    input  wire logic [47:0] err_mask,  // Entries answered in error
    input  wire logic        drop,      // Never answer
    output logic             msg_ready, // Accept
    output logic             rsp_valid, // Reply pulse
    output logic             rsp_ok     // Reply status
);
    logic [3:0] wait_q;
    logic [7:0] cnt_q;
    logic       busy_q;
    logic       ok_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msg_ready <= 1'b0;
            wait_q    <= 4'h0;
        end else if (msg_valid && msg_ready) begin
            msg_ready <= 1'b0;
            wait_q    <= 4'h0;
        end else if (msg_valid) begin
            wait_q    <= wait_q + 4'h1;
            msg_ready <= (wait_q >= rdy_lat);
        end
    end

    // Status toggles while idle so a stale level never passes for a reply
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_valid <= 1'b0;
            rsp_ok    <= 1'b0;
            busy_q    <= 1'b0;
            cnt_q     <= 8'h00;
            ok_q      <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            rsp_ok    <= ~rsp_ok;
            if (msg_valid && msg_ready) begin
                busy_q <= !drop;
                cnt_q  <= rsp_lat;
                ok_q   <= !err_mask[msg_entry];
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q    <= 1'b0;
                rsp_valid <= 1'b1;
                rsp_ok    <= ok_q;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// ---- dv/pss_scheduler_tb.sv ----
// Self-checking bench of the poll scheduler with a far-side target model
`timescale 1ns/1ps
module pss_scheduler_tb;
    import pss_pkg::*;
    localparam int T  = 20;
    localparam int IV = 3;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [15:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, port_num;
    logic [31:0] hwdata, hrdata, rd, rnd;
    logic        msg_valid, msg_ready, msg_write, rsp_valid, rsp_ok;
    logic        xfer_inhibit, slave_allow, drop, track, chk_gap;
    logic [11:0] msg_local, loc[48];
    logic [15:0] msg_remote, msg_route, rem[48], rte[48];
    logic [7:0]  msg_count, rsp_lat, cnt[48];
    logic [5:0]  msg_entry, pend;
    logic [3:0]  rdy_lat;
    logic [47:0] err_mask, sts_exp;
    logic        dir[48];
    int          errors, checks, cyc, last_cyc, gap, ntake, nv, n0;

    assign hready = hreadyout;

    pss_scheduler #(.TICK_CYC(T)) i_pss_scheduler (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .port_num(port_num), .msg_valid(msg_valid), .msg_ready(msg_ready),
        .msg_write(msg_write), .msg_local(msg_local), .msg_remote(msg_remote),
        .msg_count(msg_count), .msg_route(msg_route), .msg_entry(msg_entry),
        .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .xfer_inhibit(xfer_inhibit),
        .slave_allow(slave_allow));

    pss_slave_model i_pss_slave_model (.hclk(hclk), .hresetn(hresetn),
        .msg_valid(msg_valid), .msg_entry(msg_entry), .rdy_lat(rdy_lat), .rsp_lat(rsp_lat),
        .err_mask(err_mask), .drop(drop), .msg_ready(msg_ready), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic vld(input logic [5:0] e);
        return loc[e] != 12'h000 && (loc[e] <= 12'h020 || (loc[e] >= 12'h041
            && loc[e] <= 12'h800)) && rem[e] != 16'h0000 && cnt[e] != 8'h00
            && cnt[e] <= 8'h80 && rte[e] != 16'h0000;
    endfunction

    function automatic logic [5:0] nxt(input logic [5:0] e);
        for (int k = 1; k <= 48; k++)
            if (vld(6'((int'(e) + k) % 48))) return 6'((int'(e) + k) % 48);
        return 6'h00;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail_out;
        errors++;
        complete_run();
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) fail_out();
    endtask

    task automatic bus(input logic [13:0] i, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {i, 2'b00};
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [13:0] i, input logic [31:0] d);
        bus(i, 1'b1, d);
    endtask

    task automatic rchk(input logic [13:0] i, input logic [31:0] e);
        bus(i, 1'b0, 32'h0000_0000);
        cmp(rd, e);
    endtask

    task automatic sts_chk;
        rchk(PSS_IDX_STAT0, {16'h0000, sts_exp[15:0]});
        rchk(PSS_IDX_STAT1, {16'h0000, sts_exp[31:16]});
        rchk(PSS_IDX_STAT2, {16'h0000, sts_exp[47:32]});
    endtask

    task automatic wait_takes(input int n);
        int t0, k;
        t0 = ntake;
        k = 0;
        while (ntake < t0 + n && k < 60000) begin
            @(posedge hclk);
            k++;
        end
        if (k >= 60000) fail_out();
    endtask

    task automatic idle_chk(input int n);
        int b;
        b = 0;
        repeat (n) begin
            @(posedge hclk);
            if (msg_valid !== 1'b0) b++;
        end
        cmp(32'(b), 32'h0);
    endtask

    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (hresetn === 1'b1 && rsp_valid === 1'b1)
            sts_exp[pend] = !err_mask[pend];
        if (hresetn === 1'b1 && msg_valid === 1'b1 && msg_ready === 1'b1) begin
            cmp(32'(vld(msg_entry)), 32'h1);
            if (track)
                cmp(32'(msg_entry), 32'(nxt(pend)));
            cmp(32'(msg_local), 32'(loc[msg_entry]));
            cmp(32'(msg_remote), 32'(rem[msg_entry]));
            cmp(32'(msg_count), 32'(cnt[msg_entry]));
            cmp(32'(msg_write), 32'(dir[msg_entry]));
            cmp(32'(msg_route), 32'(rte[msg_entry]));
            if (chk_gap)
                cmp(32'(cyc - last_cyc >= gap && cyc - last_cyc <= gap + 80), 32'h1);
            gap = IV * T + (drop ? 200 * T : 0);
            if (drop) sts_exp[msg_entry] = 1'b0;
            last_cyc = cyc;
            pend = msg_entry;
            track = 1'b1;
            chk_gap = 1'b1;
            ntake++;
        end
    end

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        repeat (100000) @(posedge hclk);
        fail_out();
    end

    initial begin
        {hresetn, hsel, hwrite, drop, track, chk_gap} = '0;
        {haddr, htrans, hwdata, err_mask, sts_exp, pend} = '0;
        {errors, checks, cyc, last_cyc, gap, ntake, nv} = '0;
        hsize = 3'h2;
        port_num = 3'h2;
        rdy_lat = 4'h2;
        rsp_lat = 8'h04;
        rnd = 32'h65266146;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(PSS_IDX_WD_TIMER, 32'h0);
        cmp(32'(hresp), 32'h0);
        rchk(PSS_IDX_WD_MASK, 32'h0);
        rchk(PSS_IDX_INTERVAL, 32'h0);
        wr(PSS_IDX_STAT0, 32'h0000_FFFF);
        rchk(PSS_IDX_STAT0, 32'h0);
        rchk(14'h0010, 32'h0);
        cmp(32'(xfer_inhibit), 32'h0);
        for (int e = 0; e < 48; e++) begin
            rnd = xs(rnd);
            loc[e] = rnd[31] ? 12'(rnd[4:0]) + 12'h001 : 12'(rnd[10:0] % 11'd1984) + 12'h041;
            rem[e] = rnd[15:0] | 16'h0001;
            cnt[e] = (e > 12 && rnd[28]) ? 8'h00 : 8'(rnd[22:16]) + 8'h01;
            rte[e] = {8'h29, rnd[30:23] | 8'h01};
            dir[e] = rnd[29];
            // Range edges of local and count, both sides; remote and route at zero
            case (e)
                1: loc[e] = 12'h021;
                2: loc[e] = 12'h040;
                3: {loc[e], cnt[e], rem[e]} = {12'h020, 8'h80, 16'hFFFF};
                4: loc[e] = 12'h801;
                5: cnt[e] = 8'h81;
                6: loc[e] = 12'h041;
                7: rem[e] = 16'h0000;
                8: rte[e] = 16'h0000;
                9: loc[e] = 12'h800;
                10: cnt[e] = 8'h00;
                11: loc[e] = 12'h000;
                47: {loc[e], cnt[e]} = {12'h001, 8'h01};
                default: ;
            endcase
            nv += int'(vld(6'(e)));
            wr(PSS_IDX_TBL + 14'(2 * e), {dir[e], 3'h0, loc[e], rem[e]});
            wr(PSS_IDX_TBL + 14'(2 * e + 1), {8'h00, rte[e], cnt[e]});
        end
        cmp(32'(xfer_inhibit), 32'h1);
        wr(PSS_IDX_CTRL, 32'h1);
        idle_chk(300);
        // Interval well over three times the model's reply time
        wr(PSS_IDX_INTERVAL, 32'(IV));
        wait_takes(2 * nv);
        @(negedge hclk);
        cmp(32'(slave_allow), 32'h0);
        @(posedge hclk);
        wr(PSS_IDX_CTRL, 32'h0);
        @(negedge hclk);
        cmp(32'(slave_allow), 32'h1);
        @(posedge hclk);
        repeat (20) @(posedge hclk);
        sts_chk();
        err_mask <= 48'h8000_0000_0008;
        wait_takes(nv + 1);
        repeat (20) @(posedge hclk);
        sts_chk();
        drop <= 1'b1;
        wait_takes(1);
        drop <= 1'b0;
        wait_takes(1);
        repeat (20) @(posedge hclk);
        sts_chk();
        wr(PSS_IDX_WD_MASK, 32'h8);
        wait_takes(2);
        wr(PSS_IDX_WD_MASK, 32'h4);
        chk_gap = 1'b0;
        track = 1'b0;
        idle_chk(200);
        sts_exp = '0;
        sts_chk();
        n0 = ntake;
        wr(PSS_IDX_WD_TIMER, 32'h8);
        repeat (3 * T) @(posedge hclk);
        bus(PSS_IDX_WD_TIMER, 1'b0, 32'h0);
        cmp(32'(rd >= 32'h4 && rd <= 32'h6), 32'h1);
        cmp(32'(ntake > n0), 32'h1);
        repeat (6 * T) @(posedge hclk);
        rchk(PSS_IDX_WD_TIMER, 32'h0);
        chk_gap = 1'b0;
        idle_chk(200);
        n0 = ntake;
        // Keep-alive rewrites arrive well inside the eight-tick timeout
        repeat (6) begin
            wr(PSS_IDX_WD_TIMER, 32'h8);
            repeat (100) @(posedge hclk);
        end
        cmp(32'(ntake - n0 > 5), 32'h1);
        complete_run();
    end
endmodule
